/* src/pss_defines.svh */
// Offsets, field positions, reset values and timing figures of the sequencer
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Clock rate in MHz (period 4 ns)
`define PSS_CLK_MHZ 250

// Register port
`define PSS_ADDR_W 8
`define PSS_MODEM_ADDR 8'h29
`define PSS_MODEM_LAUNCH_BIT 1
`define PSS_MODEM_OFF_BIT 0
`define PSS_MODEM_OFF_RST 1'b1

// Synchronised input positions
`define PSS_NIN 10
`define PSS_IN_SLP0 0
`define PSS_IN_SLP3 1
`define PSS_IN_SLP4 2
`define PSS_IN_ACK 3
`define PSS_IN_RSM 4
`define PSS_IN_PLT 5
`define PSS_IN_BTN 6
`define PSS_IN_SUP 7
`define PSS_IN_OT 8
`define PSS_IN_TT 9

// Rail positions, in bring-up order
`define PSS_NRAIL 13
`define PSS_RAIL_FIRST 4'h0
`define PSS_SUS_LAST 4'h3
`define PSS_U_RAIL 4'h4
`define PSS_S_FIRST 4'h5
`define PSS_TERM_RAIL 4'hB
`define PSS_SX_RAIL 4'hC

// Timer width and times
`define PSS_TMR_W 24
`define PSS_RAMP_CYC 64
`define PSS_MDM_LEAD_US 400
`define PSS_MDM_OFF_US 14000
`define PSS_MDM_TAIL_US 5000
`define PSS_BTN_UNIT_US 1000

`endif

/* src/pss_pkg.sv */
// Types shared by the power state sequencer modules
`include "pss_defines.svh"

package pss_pkg;

  // Power sequencing states
  typedef enum logic [3:0] {
    ST_OFF, ST_UP, ST_DOWN, ST_WAIT_SLP, ST_PWROK,
    ST_S0, ST_S0IX, ST_S3, ST_S4
  } pss_state_t;

  // Modem reset sequence states
  typedef enum logic [1:0] {
    M_IDLE, M_LEAD, M_HOLD, M_TAIL
  } pss_mdm_t;

  // Timer count word
  typedef logic [`PSS_TMR_W-1:0] pss_cnt_t;

  // Timer state
  typedef struct packed {
    pss_cnt_t cnt;
    logic done;
  } pss_tmr_t;

  // Sequencer state
  typedef struct packed {
    logic [`PSS_NIN-1:0] sync1;
    logic [`PSS_NIN-1:0] sync2;
    pss_state_t state;
    pss_state_t ret;
    logic [3:0] idx;
    logic [3:0] last;
    logic busy;
    logic booting;
    logic [`PSS_NRAIL-1:0] rail_en;
    logic psave;
    logic pgood;
    logic rst_rel_n;
    logic port_rst;
    logic b_arm;
    logic btn_expired;
    logic ws;
    logic bs;
    logic bstop;
    pss_mdm_t mst;
    logic ms;
    pss_cnt_t ml;
    logic modem_off;
    logic sdwn_n;
    logic [7:0] rdata;
  } pss_main_t;

endpackage

/* src/pss_tmr_if.sv */
// Start, stop and expiry signals between the sequencer and a timer
`timescale 1ns/1ps

interface pss_tmr_if;
  logic start;
  pss_pkg::pss_cnt_t load;
  logic stop;
  logic done;
  logic busy;

  // Sequencer side
  modport ctl (output start, output load, output stop, input done,
    input busy);
  // Timer side
  modport tmr (input start, input load, input stop, output done,
    output busy);
endinterface

/* src/pss_timer.sv */
// Down-counting delay timer with a one-cycle expiry pulse
`timescale 1ns/1ps

module pss_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Control
  pss_tmr_if.tmr t
);

  pss_pkg::pss_tmr_t r_reg;
  pss_pkg::pss_tmr_t r_next;

  // Stop wins over start, so a released button never counts on
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (t.stop)
    begin
      r_next.cnt = '0;
    end
    else if (t.start)
    begin
      r_next.cnt = t.load;
    end
    else if (r_reg.cnt != '0)
    begin
      r_next.cnt = r_reg.cnt - 1'b1;
      r_next.done = (r_reg.cnt == pss_pkg::pss_cnt_t'(1));
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_reg <= '0;
    end
    else if (clk_en)
    begin
      r_reg <= r_next;
    end
  end

  assign t.done = r_reg.done;
  assign t.busy = (r_reg.cnt != '0);

endmodule

/* src/pss_sequencer.sv */
// Power state sequencer: boot, standby levels, cold off and modem reset
`timescale 1ns/1ps
`include "pss_defines.svh"

module pss_sequencer #(
  parameter int RAMP_CYC = `PSS_RAMP_CYC,
  parameter int MDM_LEAD_CYC = `PSS_MDM_LEAD_US * `PSS_CLK_MHZ,
  parameter int MDM_OFF_CYC = `PSS_MDM_OFF_US * `PSS_CLK_MHZ + 1,
  parameter int MDM_TAIL_CYC = `PSS_MDM_TAIL_US * `PSS_CLK_MHZ + 1,
  parameter int BTN_UNIT_CYC = `PSS_BTN_UNIT_US * `PSS_CLK_MHZ
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Host handshake pins
  input wire logic shallow_sleep_n,
  input wire logic sleep_level3_n,
  input wire logic deep_sleep_n,
  input wire logic suspend_powerdown_ack,
  input wire logic resume_reset_n,
  input wire logic platform_reset_n,
  // Platform events
  input wire logic power_button_n,
  input wire logic supply_threshold,
  input wire logic device_overtemp,
  input wire logic host_thermal_trip,
  input wire logic [3:0] button_hold_time,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [`PSS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Rail control
  output logic [`PSS_NRAIL-1:0] rail_en,
  output logic rail_power_save,
  output logic core_power_good,
  output logic boot_reset_n,
  // Port resets and button report
  output logic serial_port_reset,
  output logic vid_port_reset,
  output logic btn_hold_expired,
  // Modem pins
  output logic modem_power_off_n,
  output logic shutdown_warning_n
);

  localparam int TW = `PSS_TMR_W;

  pss_pkg::pss_main_t r_reg;
  pss_pkg::pss_main_t r_next;

  // One timer paces rail ramps, one the modem, one the button hold
  pss_tmr_if walk_t ();
  pss_tmr_if mdm_t ();
  pss_tmr_if btn_t ();

  // Raw pin vector, in the order of the input positions
  logic [`PSS_NIN-1:0] in_raw;
  // Synchronised levels, all read from the second stage
  logic slp0_n, slp3_n, slp4_n, ack, rsm, plt_n, btn, sup, trip;
  logic wr_modem;

  assign in_raw = {host_thermal_trip, device_overtemp, supply_threshold,
    power_button_n, platform_reset_n, resume_reset_n,
    suspend_powerdown_ack, deep_sleep_n, sleep_level3_n, shallow_sleep_n};
  assign slp0_n = r_reg.sync2[`PSS_IN_SLP0];
  assign slp3_n = r_reg.sync2[`PSS_IN_SLP3];
  assign slp4_n = r_reg.sync2[`PSS_IN_SLP4];
  assign ack = r_reg.sync2[`PSS_IN_ACK];
  assign rsm = r_reg.sync2[`PSS_IN_RSM];
  assign plt_n = r_reg.sync2[`PSS_IN_PLT];
  assign btn = !r_reg.sync2[`PSS_IN_BTN];
  assign sup = r_reg.sync2[`PSS_IN_SUP];
  assign trip = r_reg.sync2[`PSS_IN_OT] | r_reg.sync2[`PSS_IN_TT];
  assign wr_modem = reg_sel && reg_wr && (reg_addr == `PSS_MODEM_ADDR);

  // Timer hookup; starts come from registered fields, and only the modem load is registered
  assign walk_t.start = r_reg.ws;
  assign walk_t.load = TW'(RAMP_CYC);
  assign walk_t.stop = 1'b0;
  assign mdm_t.start = r_reg.ms;
  assign mdm_t.load = r_reg.ml;
  assign mdm_t.stop = 1'b0;
  assign btn_t.start = r_reg.bs;
  assign btn_t.load = TW'((int'(button_hold_time) + 1) * BTN_UNIT_CYC);
  assign btn_t.stop = r_reg.bstop;

  pss_timer u_walk (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .t(walk_t.tmr)
  );

  pss_timer u_mdm (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .t(mdm_t.tmr)
  );

  pss_timer u_btn (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .t(btn_t.tmr)
  );

  // Next-state logic for the whole sequencer
  always_comb
  begin
    r_next = r_reg;
    // Two-stage synchroniser on every host and event pin except button_hold_time
    r_next.sync1 = in_raw;
    r_next.sync2 = r_reg.sync1;
    r_next.ws = 1'b0;
    r_next.ms = 1'b0;
    r_next.bs = 1'b0;
    r_next.bstop = 1'b0;
    r_next.port_rst = 1'b0;

    // Button hold timer: armed on press, dropped on release
    if (btn)
    begin
      if (!r_reg.b_arm)
      begin
        r_next.bs = 1'b1;
        r_next.b_arm = 1'b1;
      end
      if (btn_t.done)
      begin
        r_next.btn_expired = 1'b1;
      end
    end
    else
    begin
      r_next.b_arm = 1'b0;
      r_next.btn_expired = 1'b0;
      r_next.bstop = r_reg.b_arm;
    end

    case (r_reg.state)
      // Battery-backed off; left only by a press with good supply
      pss_pkg::ST_OFF:
      begin
        r_next.rail_en = '0;
        r_next.pgood = 1'b0;
        r_next.rst_rel_n = 1'b0;
        r_next.psave = 1'b0;
        if (btn && sup)
        begin
          r_next.state = pss_pkg::ST_UP;
          r_next.idx = `PSS_RAIL_FIRST;
          r_next.last = `PSS_SUS_LAST;
          r_next.ret = pss_pkg::ST_WAIT_SLP;
          r_next.booting = 1'b1;
        end
      end
      // Bring one rail up, then wait out its ramp
      pss_pkg::ST_UP:
      begin
        if (!r_reg.busy)
        begin
          r_next.rail_en[r_reg.idx] = 1'b1;
          r_next.ws = 1'b1;
          r_next.busy = 1'b1;
        end
        else if (walk_t.done)
        begin
          r_next.busy = 1'b0;
          if (r_reg.idx == r_reg.last)
            r_next.state = r_reg.ret;
          else
            r_next.idx = r_reg.idx + 4'h1;
        end
      end
      // Take one rail down, then wait before the next
      pss_pkg::ST_DOWN:
      begin
        if (!r_reg.busy)
        begin
          r_next.rail_en[r_reg.idx] = 1'b0;
          r_next.ws = 1'b1;
          r_next.busy = 1'b1;
        end
        else if (walk_t.done)
        begin
          r_next.busy = 1'b0;
          if (r_reg.idx == r_reg.last)
          begin
            r_next.state = r_reg.ret;
            r_next.psave = 1'b1;
          end
          else
            r_next.idx = r_reg.idx - 4'h1;
        end
      end
      // Standby rails up; the rest waits for the host
      pss_pkg::ST_WAIT_SLP:
      begin
        if (slp3_n && slp4_n)
        begin
          r_next.state = pss_pkg::ST_UP;
          r_next.idx = `PSS_U_RAIL;
          r_next.last = 4'(`PSS_NRAIL - 1);
          r_next.ret = pss_pkg::ST_PWROK;
        end
      end
      // Power good first, platform reset release one cycle later
      pss_pkg::ST_PWROK:
      begin
        if (!r_reg.pgood)
          r_next.pgood = 1'b1;
        else
        begin
          r_next.rst_rel_n = 1'b1;
          r_next.booting = 1'b0;
          r_next.state = pss_pkg::ST_S0;
        end
      end
      // Fully on; warm reset only touches the ports
      pss_pkg::ST_S0:
      begin
        r_next.port_rst = !plt_n;
        if (rsm && !slp3_n)
        begin
          r_next.state = pss_pkg::ST_DOWN;
          r_next.idx = 4'(`PSS_NRAIL - 1);
          r_next.last = `PSS_S_FIRST;
          r_next.ret = pss_pkg::ST_S3;
        end
        else if (rsm && slp3_n && slp4_n && !slp0_n)
        begin
          r_next.rail_en[`PSS_SX_RAIL] = 1'b0;
          r_next.rail_en[`PSS_TERM_RAIL] = 1'b0;
          r_next.psave = 1'b1;
          r_next.state = pss_pkg::ST_S0IX;
        end
      end
      // Shallow sleep; core rail is left to voltage-ID commands
      pss_pkg::ST_S0IX:
      begin
        r_next.port_rst = !plt_n;
        if (rsm && !slp3_n)
        begin
          r_next.state = pss_pkg::ST_DOWN;
          r_next.idx = 4'(`PSS_NRAIL - 1);
          r_next.last = `PSS_S_FIRST;
          r_next.ret = pss_pkg::ST_S3;
        end
        else if (rsm && slp3_n && slp4_n && slp0_n)
        begin
          r_next.rail_en[`PSS_SX_RAIL] = 1'b1;
          r_next.rail_en[`PSS_TERM_RAIL] = 1'b1;
          r_next.psave = 1'b0;
          r_next.state = pss_pkg::ST_S0;
        end
      end
      // Sleep: deep sleep entry or exit back up to fully on
      pss_pkg::ST_S3:
      begin
        if (rsm && !slp3_n && !slp4_n)
        begin
          r_next.state = pss_pkg::ST_DOWN;
          r_next.idx = `PSS_U_RAIL;
          r_next.last = `PSS_U_RAIL;
          r_next.ret = pss_pkg::ST_S4;
        end
        else if (slp3_n)
        begin
          r_next.psave = 1'b0;
          r_next.state = pss_pkg::ST_UP;
          r_next.idx = `PSS_S_FIRST;
          r_next.last = 4'(`PSS_NRAIL - 1);
          r_next.ret = pss_pkg::ST_S0;
        end
      end
      // Deep sleep: cold off only under the full handshake
      pss_pkg::ST_S4:
      begin
        if (ack && !slp4_n && rsm)
          r_next.state = pss_pkg::ST_OFF;
        else if (slp4_n)
        begin
          r_next.state = pss_pkg::ST_UP;
          r_next.idx = `PSS_U_RAIL;
          r_next.last = `PSS_U_RAIL;
          r_next.ret = pss_pkg::ST_S3;
        end
      end
      default:
        r_next.state = pss_pkg::ST_OFF;
    endcase

    // Thermal or supply loss beats any rail sequence, no task list
    if (trip || (!sup && r_reg.state != pss_pkg::ST_OFF))
    begin
      r_next.state = pss_pkg::ST_OFF;
      r_next.rail_en = '0;
      r_next.pgood = 1'b0;
      r_next.rst_rel_n = 1'b0;
      r_next.busy = 1'b0;
      r_next.booting = 1'b0;
      r_next.psave = 1'b0;
    end
    if (r_next.booting)
      r_next.psave = 1'b0;

    // Modem reset sequence; the off bit is the pin itself
    case (r_reg.mst)
      pss_pkg::M_IDLE:
      begin
        if (wr_modem && reg_wdata[`PSS_MODEM_LAUNCH_BIT])
        begin
          r_next.sdwn_n = 1'b0;
          r_next.ms = 1'b1;
          r_next.ml = TW'(MDM_LEAD_CYC);
          r_next.mst = pss_pkg::M_LEAD;
        end
        else if (wr_modem)
          r_next.modem_off = reg_wdata[`PSS_MODEM_OFF_BIT];
      end
      pss_pkg::M_LEAD:
      begin
        if (mdm_t.done)
        begin
          r_next.modem_off = 1'b0;
          r_next.ms = 1'b1;
          r_next.ml = TW'(MDM_OFF_CYC);
          r_next.mst = pss_pkg::M_HOLD;
        end
      end
      pss_pkg::M_HOLD:
      begin
        if (mdm_t.done)
        begin
          r_next.modem_off = 1'b1;
          r_next.ms = 1'b1;
          r_next.ml = TW'(MDM_TAIL_CYC);
          r_next.mst = pss_pkg::M_TAIL;
        end
      end
      pss_pkg::M_TAIL:
      begin
        if (mdm_t.done)
        begin
          r_next.sdwn_n = 1'b1;
          r_next.mst = pss_pkg::M_IDLE;
        end
      end
      default:
        r_next.mst = pss_pkg::M_IDLE;
    endcase

    // Read data; the launch bit always returns zero
    if (reg_sel && !reg_wr)
    begin
      if (reg_addr == `PSS_MODEM_ADDR)
        r_next.rdata = {7'h00, r_reg.modem_off};
      else
        r_next.rdata = 8'h00;
    end
  end

  // State register; modem off and warning pins idle high
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_reg <= '0;
      r_reg.modem_off <= `PSS_MODEM_OFF_RST;
      r_reg.sdwn_n <= 1'b1;
    end
    else if (clk_en)
    begin
      r_reg <= r_next;
    end
  end

  // Outputs, all straight from the state register
  assign reg_rdata = r_reg.rdata;
  assign rail_en = r_reg.rail_en;
  assign rail_power_save = r_reg.psave;
  assign core_power_good = r_reg.pgood;
  assign boot_reset_n = r_reg.rst_rel_n;
  assign serial_port_reset = r_reg.port_rst;
  assign vid_port_reset = r_reg.port_rst;
  assign btn_hold_expired = r_reg.btn_expired;
  assign modem_power_off_n = r_reg.modem_off;
  assign shutdown_warning_n = r_reg.sdwn_n;

  a_pgood_all_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(core_power_good) |-> (&rail_en) && !boot_reset_n)
    else $error("power good rose before all rails were on");
  a_reset_after_pg: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(boot_reset_n) |-> $past(core_power_good))
    else $error("reset released without power good");
  a_boot_no_psave: assert property (@(posedge sys_clk) disable iff (!rst_b)
    r_reg.booting |-> !rail_power_save)
    else $error("power save during cold boot");
  a_one_rail_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(trip) && $past(sup) && $past(r_reg.state) == pss_pkg::ST_UP
    |-> $countones(rail_en ^ $past(rail_en)) <= 1)
    else $error("more than one rail changed in a step");
  a_boot_waits: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (r_reg.state == pss_pkg::ST_WAIT_SLP && !(slp3_n && slp4_n) && clk_en
    && !trip && sup) |=> r_reg.state == pss_pkg::ST_WAIT_SLP && !rail_en[4])
    else $error("boot went on under deep sleep");
  a_warm_keeps: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (r_reg.state == pss_pkg::ST_S0 && !plt_n && slp3_n && slp0_n
    && clk_en && !trip && sup) |=> serial_port_reset && $stable(rail_en))
    else $error("warm reset disturbed rails or missed ports");
  a_thermal_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && trip) |=> rail_en == '0 && !core_power_good)
    else $error("rails survived a thermal event");
  a_cold_off_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (r_reg.state == pss_pkg::ST_S4 && clk_en && ack && rsm && !slp4_n)
    |=> r_reg.state == pss_pkg::ST_OFF)
    else $error("cold off handshake not honoured");
  a_launch_warn: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && wr_modem && reg_wdata[1] && r_reg.mst == pss_pkg::M_IDLE)
    |=> !shutdown_warning_n && modem_power_off_n)
    else $error("modem launch did not start the sequence");
  a_modem_lead: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(shutdown_warning_n) |-> modem_power_off_n [*8])
    else $error("modem off fell too soon after warning");
  a_off_bit_pin: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && wr_modem && !reg_wdata[1] && r_reg.mst == pss_pkg::M_IDLE)
    |=> modem_power_off_n == $past(reg_wdata[0]))
    else $error("modem off bit did not reach the pin");

endmodule

/* sim/pss_host_model.sv */
// Host model that drives the sleep, acknowledge and warm reset pins
`timescale 1ns/1ps

module pss_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wanted depth: 0 on, 1 shallow, 2 sleep, 3 deep, 4 off
  input wire logic [2:0] depth,
  input wire logic warm,
  // Handshake pins
  output logic shallow_sleep_n,
  output logic sleep_level3_n,
  output logic deep_sleep_n,
  output logic suspend_powerdown_ack,
  output logic resume_reset_n,
  output logic platform_reset_n
);
  // Pins move on clock edges so deep sleep can only follow sleep
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Resume reset held while the host itself is in reset
      shallow_sleep_n <= 1'b1;
      sleep_level3_n <= 1'b1;
      deep_sleep_n <= 1'b1;
      suspend_powerdown_ack <= 1'b0;
      resume_reset_n <= 1'b0;
      platform_reset_n <= 1'b1;
    end
    else
    begin
      resume_reset_n <= 1'b1;
      shallow_sleep_n <= (depth != 3'h1);
      // Voltage-ID and state setup assumed done before this edge
      sleep_level3_n <= (depth < 3'h2);
      deep_sleep_n <= !(depth >= 3'h3 && !sleep_level3_n);
      // Acknowledge only once deep sleep is already low
      suspend_powerdown_ack <= (depth == 3'h4) && !deep_sleep_n;
      platform_reset_n <= !warm;
    end
  end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the power state sequencer
`timescale 1ns/1ps

module testbench;
  // Clock, reset and stimulus
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] depth = 3'h2;
  logic warm = 1'b0;
  logic clk_en = 1'b1;
  logic power_button_n = 1'b1;
  logic supply_threshold = 1'b1;
  logic device_overtemp = 1'b0;
  logic host_thermal_trip = 1'b0;
  logic [3:0] button_hold_time = 4'h1;
  logic reg_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  // Host pins and design outputs
  logic s0_n, s3_n, s4_n, ack, rsm_n, plt_n;
  logic [7:0] reg_rdata;
  logic [12:0] rail_en;
  logic rail_power_save, core_power_good, boot_reset_n;
  logic serial_port_reset, vid_port_reset, btn_hold_expired;
  logic modem_power_off_n, shutdown_warning_n;
  int num_errors = 0;
  int n_compared = 0;
  int n;

  // Short counts keep the run small
  pss_sequencer #(.RAMP_CYC(4), .MDM_LEAD_CYC(20), .MDM_OFF_CYC(40),
    .MDM_TAIL_CYC(30), .BTN_UNIT_CYC(10)) DUT (.sys_clk(sys_clk),
    .rst_b(rst_b), .clk_en(clk_en), .shallow_sleep_n(s0_n),
    .sleep_level3_n(s3_n), .deep_sleep_n(s4_n),
    .suspend_powerdown_ack(ack), .resume_reset_n(rsm_n),
    .platform_reset_n(plt_n), .power_button_n(power_button_n),
    .supply_threshold(supply_threshold),
    .device_overtemp(device_overtemp),
    .host_thermal_trip(host_thermal_trip),
    .button_hold_time(button_hold_time), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rail_en(rail_en),
    .rail_power_save(rail_power_save),
    .core_power_good(core_power_good), .boot_reset_n(boot_reset_n),
    .serial_port_reset(serial_port_reset),
    .vid_port_reset(vid_port_reset), .btn_hold_expired(btn_hold_expired),
    .modem_power_off_n(modem_power_off_n),
    .shutdown_warning_n(shutdown_warning_n));

  pss_host_model host (.sys_clk(sys_clk), .rst_b(rst_b), .depth(depth),
    .warm(warm), .shallow_sleep_n(s0_n), .sleep_level3_n(s3_n),
    .deep_sleep_n(s4_n), .suspend_powerdown_ack(ack),
    .resume_reset_n(rsm_n), .platform_reset_n(plt_n));

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // Compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register write, taken at the next edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_sel = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    // Idle cycle so a following access never re-raises the strobe at once
    @(posedge sys_clk);
    #1;
  endtask

  // One register read; data settles one edge after the request
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_sel = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_sel = 1'b0;
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, e);
  endtask

  // Bounded wait for a rail pattern, then compare
  task wait_rails(input logic [12:0] e, input int lim);
    n = 0;
    while (rail_en !== e && n < lim)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(rail_en, e);
  endtask

  task done_test(input string s);
    $display("test %0s done", s);
  endtask

  // Bounded wait for power good; it trails the last rail by one ramp
  task wait_pg;
    n = 0;
    while (core_power_good !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  // Bring the machine from off to fully on with the button
  task boot;
    power_button_n = 1'b0;
    wait_rails(13'h1FFF, 300);
    power_button_n = 1'b1;
    wait_pg();
    chk(core_power_good, 1'b1);
  endtask

  // Rails always form a low contiguous run, so they rise in order
  always @(negedge sys_clk)
    if (rst_b)
      chk(rail_en & (rail_en + 13'h1), 16'h0);

  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: the tests need well under 10000 cycles
  initial
  begin
    #100000;
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    chk({rail_en, core_power_good}, 16'h0);
    chk({modem_power_off_n, shutdown_warning_n}, 2'h3);
    rd(8'h29, 8'h01);
    wr(8'h2A, 8'hFF);
    rd(8'h2A, 8'h00);
    done_test("reset");
    // Boot with sleep held: only the standby rails come up
    power_button_n = 1'b0;
    wait_rails(13'h000F, 200);
    repeat (30) @(posedge sys_clk);
    #1;
    chk(rail_en, 13'h000F);
    chk(rail_power_save, 1'b0);
    chk(btn_hold_expired, 1'b1);
    power_button_n = 1'b1;
    depth = 3'h0;
    wait_pg();
    chk({rail_en, boot_reset_n}, {13'h1FFF, 1'b0});
    @(posedge sys_clk);
    #1;
    chk(boot_reset_n, 1'b1);
    chk(btn_hold_expired, 1'b0);
    done_test("cold boot");
    // Warm reset keeps rails and configuration
    wr(8'h29, 8'h00);
    chk(modem_power_off_n, 1'b0);
    warm = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk({serial_port_reset, vid_port_reset}, 2'h3);
    chk(rail_en, 13'h1FFF);
    warm = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk({serial_port_reset, vid_port_reset}, 2'h0);
    rd(8'h29, 8'h00);
    wr(8'h29, 8'h01);
    done_test("warm reset");
    // Shallow sleep entry and exit
    // Enable low freezes the machine: no entry while it stays low
    clk_en = 1'b0;
    depth = 3'h1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk({rail_en, rail_power_save}, {13'h1FFF, 1'b0});
    clk_en = 1'b1;
    wait_rails(13'h07FF, 20);
    chk(rail_power_save, 1'b1);
    depth = 3'h0;
    wait_rails(13'h1FFF, 20);
    chk(rail_power_save, 1'b0);
    done_test("shallow sleep");
    // Modem sequence: lead, hold, tail, with a write ignored mid-run
    wr(8'h29, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(shutdown_warning_n, 1'b0);
    n = 0;
    while (modem_power_off_n !== 1'b0 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n >= 17 && n <= 40, 1'b1);
    rd(8'h29, 8'h00);
    wr(8'h29, 8'h01);
    chk(modem_power_off_n, 1'b0);
    n = 0;
    while (modem_power_off_n !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n >= 34, 1'b1);
    n = 0;
    while (shutdown_warning_n !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n >= 29, 1'b1);
    rd(8'h29, 8'h01);
    wr(8'h29, 8'h00);
    repeat (30) @(posedge sys_clk);
    #1;
    chk(shutdown_warning_n, 1'b1);
    wr(8'h29, 8'h01);
    done_test("modem reset");
    // Both thermal events drop every rail; supply low blocks boot
    for (int e = 0; e < 2; e++)
    begin
      device_overtemp = (e == 0);
      host_thermal_trip = (e == 1);
      wait_rails(13'h0000, 5);
      device_overtemp = 1'b0;
      host_thermal_trip = 1'b0;
      supply_threshold = 1'b0;
      power_button_n = 1'b0;
      repeat (20) @(posedge sys_clk);
      #1;
      chk(rail_en, 13'h0000);
      supply_threshold = 1'b1;
      boot();
    end
    done_test("thermal");
    // Sleep, deep sleep, refused then granted cold off
    depth = 3'h2;
    wait_rails(13'h001F, 200);
    depth = 3'h3;
    wait_rails(13'h000F, 100);
    repeat (20) @(posedge sys_clk);
    #1;
    chk(rail_en, 13'h000F);
    depth = 3'h4;
    wait_rails(13'h0000, 10);
    repeat (40) @(posedge sys_clk);
    #1;
    chk(rail_en, 13'h0000);
    done_test("cold off");
    conclude();
  end
endmodule
